// File: core/pm_meter.sv
// panel meter value path, limit outputs, startup hold and register port
`timescale 1ns/1ps
module pm_meter #(
	parameter int unsigned KEY_CYC  = pm_pkg::KEY_HOLD_CYC,
	parameter int unsigned TICK_CYC = pm_pkg::HOLD_TICK_CYC,
	parameter int unsigned GATE_CYC = pm_pkg::GATE_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// analog front end, same clock, microamps or millivolts
	input  wire logic [31:0] adc_code,
	input  wire logic        adc_valid,
	// pins
	input  wire logic        pulse_in,
	input  wire logic        level_key_b,
	// comparative outputs and indicator
	output logic             cmp_out_one,
	output logic             cmp_out_two,
	output logic      [31:0] display_value,
	output logic      [2:0]  decimal_position,
	output logic             display_error,
	output logic             display_blink_ok,
	output logic             indicator_green,
	output logic             setting_level,
	// serial link settings for the link framer
	output logic      [4:0]  unit_number,
	output logic      [2:0]  link_speed,
	output logic             char_length,
	output logic             stop_bits_two,
	output logic      [1:0]  parity_mode,
	// interrupt
	output logic             irq
);
	// ==========================================================
	// reset release and pin synchronisers
	logic       rs1_r, rst_sync_b;
	logic [1:0] pin_p_r, key_p_r;
	logic       pulse_s, key_s, pulse_d_r;

	// assert at once, release after two edges
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rs1_r      <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rs1_r      <= 1'b1;
			rst_sync_b <= rs1_r;
		end
	end

	// two flops on each pin before any logic sees it
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_p_r <= 2'h0;
			key_p_r <= 2'h0;
		end else begin
			pin_p_r <= {pin_p_r[0], pulse_in};
			key_p_r <= {key_p_r[0], ~level_key_b};
		end
	end
	assign pulse_s = pin_p_r[1];
	assign key_s   = key_p_r[1];

	// ==========================================================
	// configuration registers
	logic        [12:0] ctrl_r, comm_r;
	logic signed [31:0] in1_r, dsp1_r, in2_r, dsp2_r, sp1_r, sp2_r, az_r, remote_r;
	logic        [31:0] hyst_r;
	logic        [1:0]  kind_r;
	logic        [15:0] hold_r;
	localparam int unsigned N_EV = pm_pkg::N_IRQ;
	logic        [N_EV-1:0] irq_st_r, irq_en_r;
	logic               wr_ctrl, remote_wr;
	logic        [1:0]  new_type;

	assign wr_ctrl   = reg_wr && reg_addr == pm_pkg::A_CTRL;
	assign remote_wr = reg_wr && reg_addr == pm_pkg::A_REMOTE;
	assign new_type  = reg_wdata[pm_pkg::F_TYPE +: 2];

	// control word; a new input type drops range back to default
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_r <= {11'h000, pm_pkg::PM_IN_ANALOG};
		end else if (wr_ctrl) begin
			ctrl_r <= reg_wdata[12:0];
			if (new_type != ctrl_r[pm_pkg::F_TYPE +: 2])
				ctrl_r[pm_pkg::F_RANGE +: 2] <= pm_pkg::PM_R_4_20;
		end
	end

	// scaling pairs, reset to defaults on any type change
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			in1_r  <= pm_pkg::IN1_DEF;
			dsp1_r <= pm_pkg::DSP1_DEF;
			in2_r  <= pm_pkg::IN2_DEF;
			dsp2_r <= pm_pkg::DSP2_DEF;
		end else if (wr_ctrl && new_type != ctrl_r[pm_pkg::F_TYPE +: 2]) begin
			in1_r  <= pm_pkg::IN1_DEF;
			dsp1_r <= pm_pkg::DSP1_DEF;
			in2_r  <= pm_pkg::IN2_DEF;
			dsp2_r <= pm_pkg::DSP2_DEF;
		end else if (reg_wr) begin
			if (reg_addr == pm_pkg::A_IN1)  in1_r  <= reg_wdata;
			if (reg_addr == pm_pkg::A_DSP1) dsp1_r <= reg_wdata;
			if (reg_addr == pm_pkg::A_IN2)  in2_r  <= reg_wdata;
			if (reg_addr == pm_pkg::A_DSP2) dsp2_r <= reg_wdata;
		end
	end

	// limits, hysteresis, auto-zero, hold time, link settings, remote value
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sp1_r    <= pm_pkg::ZERO32;
			sp2_r    <= pm_pkg::ZERO32;
			hyst_r   <= 32'h0000_0000;
			kind_r   <= 2'h3;
			az_r     <= pm_pkg::ZERO32;
			hold_r   <= pm_pkg::HOLD_DEF_TENTHS;
			comm_r   <= pm_pkg::COMM_DEF;
			remote_r <= pm_pkg::ZERO32;
		end else if (reg_wr) begin
			if (reg_addr == pm_pkg::A_SP1)    sp1_r    <= reg_wdata;
			if (reg_addr == pm_pkg::A_SP2)    sp2_r    <= reg_wdata;
			if (reg_addr == pm_pkg::A_HYST)   hyst_r   <= reg_wdata;
			if (reg_addr == pm_pkg::A_KIND)   kind_r   <= reg_wdata[1:0];
			if (reg_addr == pm_pkg::A_AZ)     az_r     <= reg_wdata;
			if (reg_addr == pm_pkg::A_HOLD)   hold_r   <= reg_wdata[15:0];
			if (reg_addr == pm_pkg::A_COMM)   comm_r   <= reg_wdata[12:0];
			if (remote_wr)                    remote_r <= reg_wdata;
		end
	end

	// link settings drive the framer directly
	assign unit_number   = comm_r[4:0];
	assign link_speed    = comm_r[7:5];
	assign char_length   = comm_r[8];
	assign stop_bits_two = comm_r[9];
	assign parity_mode   = comm_r[11:10];

	// ==========================================================
	// sample sources
	logic [1:0]         in_type, rng;
	logic signed [31:0] samp, lo, hi;
	logic               samp_v, gate_end;
	logic [31:0]        gate_cnt_r, pcount_r, freq_r;

	assign in_type = ctrl_r[pm_pkg::F_TYPE +: 2];
	assign rng     = ctrl_r[pm_pkg::F_RANGE +: 2];

	// pulse rate: rising edges counted over a fixed gate
	assign gate_end = gate_cnt_r >= GATE_CYC - 1;
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			gate_cnt_r <= 32'h0000_0000;
			pcount_r   <= 32'h0000_0000;
			freq_r     <= 32'h0000_0000;
			pulse_d_r  <= 1'b0;
		end else begin
			pulse_d_r  <= pulse_s;
			gate_cnt_r <= gate_end ? 32'h0000_0000 : gate_cnt_r + 32'h0000_0001;
			if (gate_end) begin
				freq_r   <= pcount_r;
				pcount_r <= 32'h0000_0000;
			end else if (pulse_s && !pulse_d_r) begin
				pcount_r <= pcount_r + 32'h0000_0001;
			end
		end
	end

	// source select
	always_comb begin
		samp   = adc_code;
		samp_v = adc_valid;
		unique case (in_type)
			pm_pkg::PM_IN_PULSE: begin
				samp   = freq_r;
				samp_v = gate_end;
			end
			pm_pkg::PM_IN_REMOTE: begin
				// the written word is the sample; the register only updates at this edge
				samp   = remote_wr ? reg_wdata : remote_r;
				samp_v = remote_wr;
			end
			default: begin
				samp   = adc_code;
				samp_v = adc_valid;
			end
		endcase
	end

	// selected analog range limits
	always_comb begin
		lo = pm_pkg::R420_LO;
		hi = pm_pkg::R420_HI;
		unique case (rng)
			pm_pkg::PM_R_4_20: begin lo = pm_pkg::R420_LO; hi = pm_pkg::R420_HI; end
			pm_pkg::PM_R_0_20: begin lo = pm_pkg::ZERO32;  hi = pm_pkg::R420_HI; end
			pm_pkg::PM_R_1_5V: begin lo = pm_pkg::R15_LO;  hi = pm_pkg::R05_HI;  end
			pm_pkg::PM_R_0_5V: begin lo = pm_pkg::ZERO32;  hi = pm_pkg::R05_HI;  end
		endcase
	end

	// ==========================================================
	// range check, averaging, scaling, auto-zero
	logic               err_r;
	logic signed [39:0] acc_r;
	logic        [7:0]  nacc_r;
	logic        [2:0]  avg_sh;
	logic signed [31:0] avg_r, pv_r;
	logic               avg_v_r, pv_v_r;
	logic signed [63:0] num;
	logic signed [31:0] den, scaled;

	assign avg_sh = ctrl_r[pm_pkg::F_AVG +: 3];

	// out-of-range only applies to analog input
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b)
			err_r <= 1'b0;
		else if (in_type != pm_pkg::PM_IN_ANALOG)
			err_r <= 1'b0;
		else if (samp_v)
			err_r <= (samp < lo) || (samp > hi);
	end

	// block average of 2^avg_sh samples
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			acc_r   <= 40'h00_0000_0000;
			nacc_r  <= 8'h00;
			avg_r   <= pm_pkg::ZERO32;
			avg_v_r <= 1'b0;
		end else begin
			avg_v_r <= 1'b0;
			if (samp_v) begin
				if (nacc_r == (8'h01 << avg_sh) - 8'h01) begin
					avg_r   <= 32'((acc_r + 40'(samp)) >>> avg_sh);
					avg_v_r <= 1'b1;
					acc_r   <= 40'h00_0000_0000;
					nacc_r  <= 8'h00;
				end else begin
					acc_r  <= acc_r + 40'(samp);
					nacc_r <= nacc_r + 8'h01;
				end
			end
		end
	end

	// straight line through the two pairs; a flat span yields the first display
	assign num    = 64'(avg_r - in1_r) * 64'(dsp2_r - dsp1_r);
	assign den    = in2_r - in1_r;
	assign scaled = (den == pm_pkg::ZERO32) ? dsp1_r : 32'(dsp1_r + 32'(num / 64'(den)));

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pv_r   <= pm_pkg::ZERO32;
			pv_v_r <= 1'b0;
		end else begin
			pv_v_r <= avg_v_r;
			if (avg_v_r)
				pv_r <= (ctrl_r[pm_pkg::F_AZEN] && scaled <= az_r) ? pm_pkg::ZERO32 : scaled;
		end
	end

	// ==========================================================
	// startup hold after power-on
	logic [31:0] tick_r;
	logic [15:0] tenths_r;
	logic        holding;

	assign holding = tenths_r < hold_r;
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tick_r   <= 32'h0000_0000;
			tenths_r <= 16'h0000;
		end else if (holding) begin
			if (tick_r >= TICK_CYC - 1) begin
				tick_r   <= 32'h0000_0000;
				tenths_r <= tenths_r + 16'h0001;
			end else begin
				tick_r <= tick_r + 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// comparators
	pm_cmp_if #(.W(32)) c1 ();
	pm_cmp_if #(.W(32)) c2 ();

	assign c1.pv       = pv_r;
	assign c1.setpoint = sp1_r;
	assign c1.hyst     = hyst_r[15:0];
	assign c1.upper    = kind_r[0];
	assign c1.hold     = holding || err_r;
	assign c2.pv       = pv_r;
	assign c2.setpoint = sp2_r;
	assign c2.hyst     = hyst_r[31:16];
	assign c2.upper    = kind_r[1];
	assign c2.hold     = holding || err_r;

	pm_limit_cmp u_cmp1 (.core_clk(core_clk), .rst_sync_b(rst_sync_b), .c(c1));
	pm_limit_cmp u_cmp2 (.core_clk(core_clk), .rst_sync_b(rst_sync_b), .c(c2));

	assign cmp_out_one = c1.active;
	assign cmp_out_two = c2.active;

	// ==========================================================
	// level key and indicator
	typedef pm_pkg::pm_lvl_e pm_lvl_t;
	logic    long_press;
	pm_lvl_t lvl_r;

	pm_key_hold #(.HOLD_CYC(KEY_CYC)) u_key (
		.core_clk  (core_clk),
		.rst_sync_b(rst_sync_b),
		.key_down  (key_s),
		.long_press(long_press)
	);

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b)
			lvl_r <= pm_pkg::PM_LVL_OPER;
		else if (long_press)
			lvl_r <= (lvl_r == pm_pkg::PM_LVL_OPER) ? pm_pkg::PM_LVL_INIT : pm_pkg::PM_LVL_OPER;
	end
	assign setting_level = (lvl_r == pm_pkg::PM_LVL_INIT);

	// display copy; the error flag goes out beside the value, and its blink gate toggles only during the startup hold
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			display_value   <= 32'h0000_0000;
			display_error   <= 1'b0;
			indicator_green <= 1'b0;
		end else begin
			display_value   <= pv_r;
			display_error   <= err_r;
			unique case (ctrl_r[pm_pkg::F_COL +: 2])
				pm_pkg::PM_COL_GREEN: indicator_green <= 1'b1;
				pm_pkg::PM_COL_GR_ON: indicator_green <= !(c1.active || c2.active);
				default:              indicator_green <= 1'b0;
			endcase
		end
	end
	assign display_blink_ok = tick_r[0] | ~err_r;
	assign decimal_position = ctrl_r[pm_pkg::F_DP +: 3];

	// ==========================================================
	// interrupts: sticky events, set wins over clear
	logic [N_EV-1:0] ev, prev_r;
	logic [N_EV-1:0] clr;
	assign ev  = {holding, setting_level, err_r, c2.active, c1.active};
	assign clr = (reg_wr && reg_addr == pm_pkg::A_IRQ_CL) ? reg_wdata[N_EV-1:0] : '0;

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prev_r   <= 5'h01 << 4;
			irq_st_r <= '0;
			irq_en_r <= '0;
		end else begin
			prev_r   <= ev;
			irq_st_r <= (irq_st_r & ~clr) | (ev ^ prev_r);
			if (reg_wr && reg_addr == pm_pkg::A_IRQ_EN)
				irq_en_r <= reg_wdata[N_EV-1:0];
		end
	end
	assign irq = |(irq_st_r & irq_en_r);

	// ==========================================================
	// register read, data in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				pm_pkg::A_CTRL:   reg_rdata <= {19'h0_0000, ctrl_r};
				pm_pkg::A_IN1:    reg_rdata <= in1_r;
				pm_pkg::A_DSP1:   reg_rdata <= dsp1_r;
				pm_pkg::A_IN2:    reg_rdata <= in2_r;
				pm_pkg::A_DSP2:   reg_rdata <= dsp2_r;
				pm_pkg::A_SP1:    reg_rdata <= sp1_r;
				pm_pkg::A_SP2:    reg_rdata <= sp2_r;
				pm_pkg::A_HYST:   reg_rdata <= hyst_r;
				pm_pkg::A_KIND:   reg_rdata <= {30'h0000_0000, kind_r};
				pm_pkg::A_AZ:     reg_rdata <= az_r;
				pm_pkg::A_HOLD:   reg_rdata <= {16'h0000, hold_r};
				pm_pkg::A_REMOTE: reg_rdata <= remote_r;
				pm_pkg::A_PV:     reg_rdata <= pv_r;
				pm_pkg::A_STAT:   reg_rdata <= {27'h000_0000, ev};
				pm_pkg::A_COMM:   reg_rdata <= {19'h0_0000, comm_r};
				pm_pkg::A_IRQ_ST: reg_rdata <= {27'h000_0000, irq_st_r};
				pm_pkg::A_IRQ_EN: reg_rdata <= {27'h000_0000, irq_en_r};
				default:          reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// File: core/pm_pkg.sv
// constants, register map and field layout of the panel meter limit block
package pm_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned KEY_HOLD_MS    = 1000;
	localparam int unsigned KEY_HOLD_CYC   = KEY_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_TICK_MS   = 100;
	localparam int unsigned HOLD_TICK_CYC  = HOLD_TICK_MS * (CLK_HZ / 1000);
	localparam int unsigned GATE_MS        = 1000;
	localparam int unsigned GATE_CYC       = GATE_MS * (CLK_HZ / 1000);
	localparam logic [15:0] HOLD_DEF_TENTHS = 16'h0032;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_IN1    = 8'h04;
	localparam logic [7:0] A_DSP1   = 8'h08;
	localparam logic [7:0] A_IN2    = 8'h0C;
	localparam logic [7:0] A_DSP2   = 8'h10;
	localparam logic [7:0] A_SP1    = 8'h14;
	localparam logic [7:0] A_SP2    = 8'h18;
	localparam logic [7:0] A_HYST   = 8'h1C;
	localparam logic [7:0] A_KIND   = 8'h20;
	localparam logic [7:0] A_AZ     = 8'h24;
	localparam logic [7:0] A_HOLD   = 8'h28;
	localparam logic [7:0] A_REMOTE = 8'h2C;
	localparam logic [7:0] A_PV     = 8'h30;
	localparam logic [7:0] A_STAT   = 8'h34;
	localparam logic [7:0] A_COMM   = 8'h38;
	localparam logic [7:0] A_IRQ_ST = 8'h3C;
	localparam logic [7:0] A_IRQ_CL = 8'h40;
	localparam logic [7:0] A_IRQ_EN = 8'h44;

	// ==========================================================
	// field positions and reset values
	localparam int unsigned F_TYPE = 0;
	localparam int unsigned F_RANGE = 2;
	localparam int unsigned F_AZEN = 4;
	localparam int unsigned F_AVG = 5;
	localparam int unsigned F_DP = 8;
	localparam int unsigned F_COL = 11;
	localparam int unsigned N_IRQ = 5;
	localparam logic [12:0] COMM_DEF = 13'h0E21;

	typedef enum logic [1:0] {PM_IN_ANALOG = 2'b00, PM_IN_PULSE = 2'b01, PM_IN_REMOTE = 2'b10}
		pm_in_e;
	typedef enum logic [1:0] {PM_R_4_20 = 2'b00, PM_R_0_20 = 2'b01, PM_R_1_5V = 2'b10,
		PM_R_0_5V = 2'b11} pm_range_e;
	typedef enum logic [1:0] {PM_COL_RED = 2'b00, PM_COL_GREEN = 2'b01, PM_COL_GR_ON = 2'b10}
		pm_col_e;
	typedef enum logic {PM_LVL_OPER = 1'b0, PM_LVL_INIT = 1'b1} pm_lvl_e;

	// range limits of the front-end code, microamps or millivolts
	localparam logic signed [31:0] R420_LO = 32'h0000_0FA0;
	localparam logic signed [31:0] R420_HI = 32'h0000_4E20;
	localparam logic signed [31:0] R15_LO  = 32'h0000_03E8;
	localparam logic signed [31:0] R05_HI  = 32'h0000_1388;
	localparam logic signed [31:0] ZERO32  = 32'h0000_0000;

	// default scaling pairs: identity over the 4 to 20 mA span
	localparam logic signed [31:0] IN1_DEF  = R420_LO;
	localparam logic signed [31:0] DSP1_DEF = R420_LO;
	localparam logic signed [31:0] IN2_DEF  = R420_HI;
	localparam logic signed [31:0] DSP2_DEF = R420_HI;
endpackage

// File: core/pm_cmp_if.sv
// interface joining the value path to one limit comparator
`timescale 1ns/1ps
interface pm_cmp_if #(parameter int W = 32);
	logic signed [W-1:0] pv;
	logic signed [W-1:0] setpoint;
	logic        [15:0]  hyst;
	logic                upper;
	logic                hold;
	logic                active;
	modport src (output pv, output setpoint, output hyst, output upper, output hold,
		input active);
	modport cmp (input pv, input setpoint, input hyst, input upper, input hold,
		output active);
endinterface

// File: core/pm_limit_cmp.sv
// one comparative output with upper or lower limit action and hysteresis
`timescale 1ns/1ps
module pm_limit_cmp (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_sync_b,
	// comparator side
	pm_cmp_if.cmp    c
);
	logic signed [32:0] hy;
	logic               act_r;

	assign hy = {17'h0_0000, c.hyst};
	assign c.active = act_r;

	// set at the limit, release once the value reaches the far edge of the hysteresis band, or while hold is high
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			act_r <= 1'b0;
		end else if (c.hold) begin
			act_r <= 1'b0;
		end else if (c.upper) begin
			if (c.pv >= c.setpoint)
				act_r <= 1'b1;
			else if (33'(c.pv) <= 33'(c.setpoint) - hy)
				act_r <= 1'b0;
		end else begin
			if (c.pv <= c.setpoint)
				act_r <= 1'b1;
			else if (33'(c.pv) >= 33'(c.setpoint) + hy)
				act_r <= 1'b0;
		end
	end
endmodule

// File: core/pm_key_hold.sv
// level key long-press detector, one pulse per press held long enough
`timescale 1ns/1ps
module pm_key_hold #(
	parameter int unsigned HOLD_CYC = pm_pkg::KEY_HOLD_CYC
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_sync_b,
	// synchronised key level, high while pressed
	input  wire logic key_down,
	// one-cycle pulse once the hold time is reached
	output logic      long_press
);
	logic [31:0] cnt_r;
	logic        done_r;

	initial begin
		if (HOLD_CYC < 1) $error("hold count must be at least one cycle");
	end

	// count while held; release resets so only an unbroken hold counts
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_r  <= 32'h0000_0000;
			done_r <= 1'b0;
		end else if (!key_down) begin
			cnt_r  <= 32'h0000_0000;
			done_r <= 1'b0;
		end else if (!done_r && cnt_r >= HOLD_CYC - 1) begin
			done_r <= 1'b1;
		end else if (!done_r) begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	assign long_press = key_down && !done_r && (cnt_r >= HOLD_CYC - 1);
endmodule

// File: verification/pm_meter_sva.sv
// assertions on the panel meter top ports
`timescale 1ns/1ps
module pm_meter_sva #(
	parameter int unsigned KEY_CYC  = 8,
	parameter int unsigned TICK_CYC = 4
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_b,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// pins and indicator
	input wire logic        level_key_b,
	input wire logic        cmp_out_one,
	input wire logic        cmp_out_two,
	input wire logic [2:0]  decimal_position,
	input wire logic        display_error,
	input wire logic        setting_level
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// cycles since reset and length of the present key press
	int unsigned up_r;
	int unsigned key_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_r  <= 0;
			key_r <= 0;
		end else begin
			up_r  <= (up_r < 100000) ? up_r + 1 : up_r; // saturate, never wraps
			key_r <= level_key_b ? 0 : key_r + 1;
		end
	end
	sequence s_rd_void;
		reg_rd && (reg_addr > 8'h44);
	endsequence
	sequence s_err_held;
		display_error [*3];
	endsequence
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 32'h0000_0000;
	endproperty
	property p_rd_void;
		s_rd_void |=> reg_rdata == 32'h0000_0000;
	endproperty
	property p_dp;
		reg_wr && reg_addr == pm_pkg::A_CTRL |=> decimal_position == $past(reg_wdata[10:8]);
	endproperty
	property p_hold;
		up_r < 50 * TICK_CYC |-> !cmp_out_one && !cmp_out_two;
	endproperty
	property p_err_off;
		s_err_held |-> !cmp_out_one && !cmp_out_two;
	endproperty
	property p_rise_ok;
		$rose(cmp_out_one) |-> !display_error;
	endproperty
	property p_key_time;
		$changed(setting_level) |-> key_r >= KEY_CYC;
	endproperty
	property p_key_still;
		level_key_b [*4] |-> $stable(setting_level);
	endproperty
	a_rd_idle:   assert property (p_rd_idle) else $error("read data outside read slot");
	a_rd_void:   assert property (p_rd_void) else $error("unmapped read not zero");
	a_dp:        assert property (p_dp) else $error("decimal position not taken");
	a_hold:      assert property (p_hold) else $error("output during startup hold");
	a_err_off:   assert property (p_err_off) else $error("output during range error");
	a_rise_ok:   assert property (p_rise_ok) else $error("output rose in error");
	a_key_time:  assert property (p_key_time) else $error("level changed on short press");
	a_key_still: assert property (p_key_still) else $error("level changed, key up");
endmodule
bind pm_meter pm_meter_sva #(.KEY_CYC(KEY_CYC), .TICK_CYC(TICK_CYC)) pm_meter_sva_inst (
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .level_key_b(level_key_b),
	.cmp_out_one(cmp_out_one), .cmp_out_two(cmp_out_two),
	.decimal_position(decimal_position), .display_error(display_error),
	.setting_level(setting_level));

// File: verification/pm_host.sv
// register-bus host standing in for the remote computer
`timescale 1ns/1ps
module pm_host (
	// clock
	input  wire logic        core_clk,
	// register port
	output logic      [7:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	// idle bus at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// one write cycle; data scrambled after so nothing stale is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// read strobe, data taken once it stands in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// periodic poll of value and output status
	task automatic poll(output logic [31:0] pv, output logic [31:0] st);
		rd(pm_pkg::A_PV, pv);
		rd(pm_pkg::A_STAT, st);
	endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the panel meter block
`timescale 1ns/1ps
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [31:0] adc_code = 32'h0000_0000;
	logic        adc_valid = 1'b0;
	logic        pulse_in = 1'b0;
	logic        level_key_b = 1'b1;
	wire  [7:0]  reg_addr;
	wire  [31:0] reg_wdata, reg_rdata, display_value;
	wire         reg_wr, reg_rd, c1, c2, derr, green, lvl, irq;
	wire  [4:0]  unit_number;
	wire  [2:0]  dp;
	logic [31:0] rv, st;
	int          err_total = 0, n_checks = 0, seed = 32'hf697, v, t, k;
	int          i1 = 4000, d1 = 4000, i2 = 20000, d2 = 20000;
	logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28};
	int          rx[6] = '{0, 4000, 4000, 20000, 20000, 50};
	always #12.5 core_clk = ~core_clk;
	// pulse pin kept busy with noise
	always @(posedge core_clk) pulse_in <= 1'($random(seed));
	pm_meter #(.KEY_CYC(8), .TICK_CYC(4), .GATE_CYC(16)) pm_meter_inst (.core_clk(core_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_code(adc_code), .adc_valid(adc_valid),
		.pulse_in(pulse_in), .level_key_b(level_key_b), .cmp_out_one(c1), .cmp_out_two(c2),
		.display_value(display_value), .decimal_position(dp), .display_error(derr),
		.display_blink_ok(), .indicator_green(green), .setting_level(lvl),
		.unit_number(unit_number), .link_speed(), .char_length(), .stop_bits_two(),
		.parity_mode(), .irq(irq));
	pm_host pm_host_inst (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// reference scaling through the two pairs
	function automatic int scl(input int x);
		return d1 + (x - i1) * (d2 - d1) / (i2 - i1);
	endfunction
	// one front-end sample, then let the value path settle
	task automatic smp(input int x);
		@(posedge core_clk);
		adc_code  <= x;
		adc_valid <= 1'b1;
		@(posedge core_clk);
		adc_valid <= 1'b0;
		adc_code  <= ~x;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		end_of_test;
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CK(unit_number, 5'h01)
		for (k = 0; k < 6; k++) begin
			pm_host_inst.rd(ra[k], rv);
			`CK(rv, 32'(rx[k]))
		end
		pm_host_inst.wr(pm_pkg::A_SP1, 32'd8000);
		pm_host_inst.wr(pm_pkg::A_SP2, 32'd30000);
		smp(10000);
		`CK(c1, 1'b0)
		repeat (200) @(posedge core_clk);
		smp(10000);
		`CK(c1, 1'b1)
		`CK(display_value, 32'(scl(10000)))
		$display("hold and upper done");
		pm_host_inst.wr(pm_pkg::A_HYST, 32'h0000_0064);
		smp(7950);
		`CK(c1, 1'b1)
		smp(7900);
		`CK(c1, 1'b0)
		smp(8000);
		`CK(c1, 1'b1)
		pm_host_inst.wr(pm_pkg::A_KIND, 32'h0000_0001);
		pm_host_inst.wr(pm_pkg::A_SP2, 32'd6000);
		smp(6001);
		`CK(c2, 1'b0)
		smp(6000);
		`CK(c2, 1'b1)
		pm_host_inst.poll(rv, st);
		`CK(rv, 32'd6000)
		`CK(st, 32'h0000_0002)
		pm_host_inst.wr(pm_pkg::A_IRQ_EN, 32'h0000_0001);
		@(posedge core_clk);
		#1 `CK(irq, 1'b1)
		pm_host_inst.wr(pm_pkg::A_IRQ_CL, 32'h0000_001F);
		@(posedge core_clk);
		#1 `CK(irq, 1'b0)
		pm_host_inst.wr(pm_pkg::A_IRQ_EN, 32'h0000_0000);
		smp(8000);
		`CK(irq, 1'b0)
		pm_host_inst.wr(pm_pkg::A_IRQ_EN, 32'h0000_0001);
		@(posedge core_clk);
		#1 `CK(irq, 1'b1)
		$display("lower, status and interrupt done");
		smp(3000);
		`CK(derr, 1'b1)
		`CK(c1, 1'b0)
		pm_host_inst.wr(pm_pkg::A_CTRL, 32'h0000_0010);
		pm_host_inst.wr(pm_pkg::A_AZ, 32'd9000);
		smp(8500);
		`CK(derr, 1'b0)
		`CK(display_value, 32'h0000_0000)
		smp(9001);
		`CK(display_value, 32'd9001)
		pm_host_inst.wr(pm_pkg::A_CTRL, 32'h0000_0040);
		for (k = 0; k < 4; k++)
			smp(10000 + 2 * k);
		`CK(display_value, 32'd10003)
		pm_host_inst.wr(pm_pkg::A_CTRL, 32'h0000_0D00);
		@(posedge core_clk);
		#1;
		`CK(dp, 3'h5)
		`CK(green, 1'b1)
		pm_host_inst.wr(pm_pkg::A_DSP1, 32'd0);
		pm_host_inst.wr(pm_pkg::A_DSP2, 32'd1600);
		d1 = 0;
		d2 = 1600;
		for (k = 0; k < 8; k++) begin
			v = 4000 + ($unsigned($random(seed)) % 16001);
			smp(v);
			`CK(display_value, 32'(scl(v)))
		end
		$display("value path done");
		pm_host_inst.wr(pm_pkg::A_CTRL, 32'h0000_0002);
		pm_host_inst.rd(pm_pkg::A_DSP2, rv);
		`CK(rv, 32'd20000)
		pm_host_inst.wr(pm_pkg::A_REMOTE, 32'd12345);
		repeat (4) @(posedge core_clk);
		#1 `CK(display_value, 32'd12345)
		level_key_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		level_key_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CK(lvl, 1'b0)
		level_key_b <= 1'b0;
		for (t = 0; t < 40 && lvl !== 1'b1; t++)
			@(posedge core_clk);
		level_key_b <= 1'b1;
		`CK(lvl, 1'b1)
		`CK(t >= 8, 1'b1)
		$display("type change and level key done");
		end_of_test;
	end
endmodule
